// ==== core/scss_top.sv ====
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
// Overview of operation
// - cpu rate is system rate halved
// - fosc = fin*(m+2)/((pre+2)*2*(post+1)) in pll modes, else fin
// - vco = fin*(m+2)/(pre+2) in pll modes, else 0
// - initial select picks startup source
// - primary kind picks crystal or external
// - erased device starts fast rc div-n
// - active source readable in bits 14:12
// - requested source writable in bits 10:8
// - config bit sets second pin function unless a crystal uses it
// - doze ratio is only stored and read back; the cpu rate ignores it
module scss_top
    import scss_pkg::*;
#(
    parameter logic [31:0] FRC_HZ = 32'h0070_0000,  // fast rc rate, plain default
    parameter logic [31:0] LOW_POWER_RC_OSC_HZ = 32'h0000_8000, // low power rc rate, plain default
    parameter logic [31:0] PRI_HZ = 32'h0080_0000   // primary input rate, plain default
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // nonvolatile configuration, from pins
    input wire logic [2:0] initial_osc_select_i,
    input wire logic [1:0] primary_osc_kind_i,
    input wire logic second_pin_function_sel_i,
    input wire logic cfg_valid_i,
    // oscillator steering outputs
    output logic [2:0] active_clock_source_o,
    output logic primary_crystal_en_o,
    output logic primary_high_gain_o,
    output logic pll_en_o,
    output logic second_pin_is_io_o
);
    typedef struct packed {
        scss_state_t state;
        logic [2:0] act;        // active_clock_source
        logic [2:0] req;        // requested_clock_source
        logic [2:0] init_sel;   // latched initial_osc_select
        logic [1:0] kind;       // latched primary_osc_kind
        logic pin_io;           // latched second_pin_function_sel
        logic cfg_done;         // configuration captured
        logic [4:0] pre;        // pll_input_divider
        logic [1:0] post;       // pll_output_divider
        logic [8:0] mul;        // pll_feedback_multiplier
        logic [2:0] doze;       // doze ratio, 0 means 1:1
        logic [3:0] sw_cnt;     // switch settle count
        logic [1:0] calc_step;  // 0 fosc, 1 vco
        logic [47:0] fosc;      // system oscillator rate
        logic [31:0] vco;       // vco rate
        logic [31:0] rdata;
        logic ack;              // one-cycle bus answer
    } scss_st_t;

    scss_st_t st_r, st_nxt;

    // two-flop synchronisers for configuration pins
    logic [6:0] cfg_meta_r, cfg_sync_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_meta_r <= '0;
            cfg_sync_r <= '0;
        end else begin
            cfg_meta_r <= {cfg_valid_i, second_pin_function_sel_i, primary_osc_kind_i, initial_osc_select_i};
            cfg_sync_r <= cfg_meta_r;
        end
    end

    // divider shared by both rate equations
    logic div_start;
    logic div_busy;
    logic [47:0] div_num, div_den, div_quo;

    scss_div #(.W(48)) u_div (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(div_start),
        .num_i(div_num),
        .den_i(div_den),
        .busy_o(div_busy),
        .quo_o(div_quo)
    );

    // input rate to the pll follows the active source
    logic [31:0] pll_input_freq;
    always_comb begin
        case (st_r.act)
            SCSS_SRC_PRI, SCSS_SRC_PRIPLL: pll_input_freq = PRI_HZ;
            SCSS_SRC_LOW_POWER_RC_OSC: pll_input_freq = LOW_POWER_RC_OSC_HZ;
            default: pll_input_freq = FRC_HZ;
        endcase
    end

    logic pll_on;
    assign pll_on = (st_r.act == SCSS_SRC_PRIPLL) || (st_r.act == SCSS_SRC_FAST_RC_WITH_PLL_MODE);

    logic [47:0] m_term, n1_term, n2_term;
    assign m_term = 48'(st_r.mul) + 48'h2;
    assign n1_term = 48'(st_r.pre) + 48'h2;
    assign n2_term = (48'(st_r.post) + 48'h1) << 1;

    logic bus_req;
    assign bus_req = (avs_read_i || avs_write_i) && !st_r.ack;

    // the taking edge is the one where waitrequest is low; writes land only there
    // so a master that drops its request early never leaves half a write behind
    logic bus_take;
    assign bus_take = (avs_read_i || avs_write_i) && st_r.ack;

    // next state: bus decode, switch sequencing and rate calculation
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = bus_req;
        div_start = 1'b0;
        div_num = 48'(pll_input_freq) * m_term;
        div_den = (st_r.calc_step == 2'h0) ? n1_term * n2_term : n1_term;

        // capture configuration once the fuses are valid
        if (!st_r.cfg_done && cfg_sync_r[6]) begin
            st_nxt.cfg_done = 1'b1;
            st_nxt.init_sel = cfg_sync_r[2:0];
            st_nxt.kind = cfg_sync_r[4:3];
            st_nxt.pin_io = cfg_sync_r[5];
            st_nxt.req = cfg_sync_r[2:0];
            st_nxt.state = SCSS_SWITCH;
            st_nxt.sw_cnt = '0;
        end

        case (st_r.state)
            SCSS_IDLE: begin
                // a new request differing from active, other than the reserved code, starts a switch
                if (st_r.req != st_r.act && st_r.req != SCSS_SRC_RSVD) begin
                    st_nxt.state = SCSS_SWITCH;
                    st_nxt.sw_cnt = '0;
                end
            end
            SCSS_SWITCH: begin
                st_nxt.sw_cnt = st_r.sw_cnt + 4'h1;
                if (st_r.sw_cnt == 4'(SCSS_SWITCH_CYC - 1)) begin
                    st_nxt.act = st_r.req;
                    st_nxt.state = SCSS_CALC;
                    st_nxt.calc_step = 2'h0;
                end
            end
            SCSS_CALC: begin
                // step 0 starts fosc, step 1 takes fosc and starts vco, step 2 takes vco
                // the divider is busy in the cycle after a start, so each step sees its own result
                case (st_r.calc_step)
                    2'h0: begin
                        if (!div_busy) begin
                            div_start = 1'b1;
                            st_nxt.calc_step = 2'h1;
                        end
                    end
                    2'h1: begin
                        if (!div_busy) begin
                            st_nxt.fosc = pll_on ? div_quo : 48'(pll_input_freq);
                            div_start = 1'b1;
                            st_nxt.calc_step = 2'h2;
                        end
                    end
                    default: begin
                        if (!div_busy) begin
                            st_nxt.vco = pll_on ? div_quo[31:0] : 32'h0;
                            st_nxt.calc_step = 2'h0;
                            st_nxt.state = SCSS_IDLE;
                        end
                    end
                endcase
            end
            default: st_nxt.state = SCSS_IDLE;
        endcase

        // register writes, gated by byte lanes 0, 1 and 2+3, applied at the taking edge only
        if (bus_take && avs_write_i) begin
            case (avs_address_i)
                SCSS_ADDR_OSC_CTRL: begin
                    if (avs_byteenable_i[1]) begin
                        st_nxt.req = avs_writedata_i[SCSS_REQ_LSB +: 3];
                    end
                end
                SCSS_ADDR_PLL_CFG: begin
                    if (avs_byteenable_i[0]) begin
                        st_nxt.pre = avs_writedata_i[SCSS_PRE_LSB +: 5];
                        st_nxt.post = avs_writedata_i[SCSS_POST_LSB +: 2];
                    end
                    if (avs_byteenable_i[2] && avs_byteenable_i[3]) begin
                        st_nxt.mul = avs_writedata_i[SCSS_DIV_LSB +: 9];
                    end
                    if (st_r.state == SCSS_IDLE) begin
                        st_nxt.state = SCSS_CALC;
                        st_nxt.calc_step = 2'h0;
                    end
                end
                SCSS_ADDR_DOZE: begin
                    if (avs_byteenable_i[0]) begin
                        st_nxt.doze = avs_writedata_i[2:0];
                    end
                end
                default: ;  // read-only or unmapped: write ignored
            endcase
        end

        // read mux; unmapped reads return zero
        if (bus_req && avs_read_i) begin
            case (avs_address_i)
                SCSS_ADDR_OSC_CTRL:
                    st_nxt.rdata = {16'h0000, 1'b0, st_r.act, 1'b0, st_r.req, 8'h00};
                SCSS_ADDR_PLL_CFG:
                    st_nxt.rdata = {7'h00, st_r.mul, 8'h00, st_r.post, 1'b0, st_r.pre};
                SCSS_ADDR_BOOT_CFG:
                    st_nxt.rdata = {23'h0, st_r.pin_io, 2'h0, st_r.kind, 1'b0, st_r.init_sel};
                SCSS_ADDR_FREQ_LO: st_nxt.rdata = st_r.fosc[31:0];
                SCSS_ADDR_FREQ_HI: st_nxt.rdata = {16'h0000, st_r.fosc[47:32]};
                SCSS_ADDR_FCY: st_nxt.rdata = st_r.fosc[32:1];
                SCSS_ADDR_VCO: st_nxt.rdata = st_r.vco;
                SCSS_ADDR_DOZE: st_nxt.rdata = {29'h0, st_r.doze};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register; erased device defaults on reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.state <= SCSS_IDLE;
            st_r.act <= SCSS_ERASED_SRC;
            st_r.req <= SCSS_ERASED_SRC;
            st_r.init_sel <= SCSS_ERASED_SRC;
            st_r.pre <= SCSS_PRE_RST;
            st_r.post <= SCSS_POST_RST;
            st_r.mul <= SCSS_DIV_RST;
            st_r.doze <= SCSS_DOZE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bus answers the cycle after a request is seen
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_r.ack;
    assign avs_readdata_o = st_r.rdata;

    // oscillator steering; kind matters only for primary sources
    logic pri_sel;
    assign pri_sel = (st_r.act == SCSS_SRC_PRI) || (st_r.act == SCSS_SRC_PRIPLL);
    assign active_clock_source_o = st_r.act;
    assign primary_crystal_en_o = pri_sel && (st_r.kind != SCSS_KIND_EC);
    assign primary_high_gain_o = pri_sel && (st_r.kind == SCSS_KIND_HS);
    assign pll_en_o = pll_on;
    // pin is free only when no crystal uses it
    assign second_pin_is_io_o = !primary_crystal_en_o && st_r.pin_io;

    // assertions
    property p_req_reaches_act;
        @(posedge sys_clk_i) disable iff (rst_i)
        (st_r.state == SCSS_SWITCH && st_r.sw_cnt == 4'(SCSS_SWITCH_CYC - 1)) |=> (st_r.act == $past(st_r.req));
    endproperty
    a_req_reaches_act: assert property (p_req_reaches_act) else $error("active source missed request");

    property p_bus_one_wait;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer not one wait");

    property p_no_reserved_act;
        @(posedge sys_clk_i) disable iff (rst_i)
        st_r.act != SCSS_SRC_RSVD;
    endproperty
    a_no_reserved_act: assert property (p_no_reserved_act) else $error("reserved source active");

    property p_kind_ignored;
        @(posedge sys_clk_i) disable iff (rst_i)
        !pri_sel |-> !primary_crystal_en_o && !primary_high_gain_o;
    endproperty
    a_kind_ignored: assert property (p_kind_ignored) else $error("kind used by internal source");

    // a taken write of the control word must show in the requested field
    property p_req_write_lands;
        @(posedge sys_clk_i) disable iff (rst_i)
        (avs_write_i && !avs_waitrequest_o && avs_address_i == SCSS_ADDR_OSC_CTRL && avs_byteenable_i[1])
            |=> (st_r.req == $past(avs_writedata_i[SCSS_REQ_LSB +: 3]));
    endproperty
    a_req_write_lands: assert property (p_req_write_lands) else $error("requested source write lost");

    // the active source moves only out of the switch sequence
    property p_act_held;
        @(posedge sys_clk_i) disable iff (rst_i)
        (st_r.state != SCSS_SWITCH) |=> $stable(st_r.act);
    endproperty
    a_act_held: assert property (p_act_held) else $error("active source moved outside switch");

    // pll runs only for the two pll modes
    property p_pll_only_pll_src;
        @(posedge sys_clk_i) disable iff (rst_i)
        pll_en_o |-> (active_clock_source_o == SCSS_SRC_FAST_RC_WITH_PLL_MODE || active_clock_source_o == SCSS_SRC_PRIPLL);
    endproperty
    a_pll_only_pll_src: assert property (p_pll_only_pll_src) else $error("pll on for non-pll source");

    // waitrequest is only raised against a live request
    property p_wait_needs_req;
        @(posedge sys_clk_i) disable iff (rst_i)
        avs_waitrequest_o |-> (avs_read_i || avs_write_i);
    endproperty
    a_wait_needs_req: assert property (p_wait_needs_req) else $error("waitrequest without request");

    // the second pin is never handed to io while a crystal drives it
    property p_pin_io_needs_free;
        @(posedge sys_clk_i) disable iff (rst_i)
        second_pin_is_io_o |-> !primary_crystal_en_o;
    endproperty
    a_pin_io_needs_free: assert property (p_pin_io_needs_free) else $error("second pin io with crystal");

    // the configuration image is latched once; its initial select must match the synchronised pins
    property p_boot_capture;
        @(posedge sys_clk_i) disable iff (rst_i)
        (!st_r.cfg_done && cfg_sync_r[6]) |=> (st_r.cfg_done && st_r.init_sel == $past(cfg_sync_r[2:0]));
    endproperty
    a_boot_capture: assert property (p_boot_capture) else $error("initial select not captured");

    // high gain is a crystal mode, never an external clock mode
    property p_high_gain_crystal;
        @(posedge sys_clk_i) disable iff (rst_i)
        primary_high_gain_o |-> primary_crystal_en_o;
    endproperty
    a_high_gain_crystal: assert property (p_high_gain_crystal) else $error("high gain without crystal");

endmodule : scss_top

// ==== core/scss_pkg.sv ====
package scss_pkg;

    // avalon word addresses, one 32-bit word per register
    localparam logic [3:0] SCSS_ADDR_OSC_CTRL = 4'h0;  // oscillator_control
    localparam logic [3:0] SCSS_ADDR_PLL_CFG = 4'h1;   // pll divider fields
    localparam logic [3:0] SCSS_ADDR_BOOT_CFG = 4'h2;  // nonvolatile config image
    localparam logic [3:0] SCSS_ADDR_FREQ_LO = 4'h3;   // computed fosc, low word
    localparam logic [3:0] SCSS_ADDR_FREQ_HI = 4'h4;   // computed fosc, high word
    localparam logic [3:0] SCSS_ADDR_FCY = 4'h5;       // computed cpu rate
    localparam logic [3:0] SCSS_ADDR_VCO = 4'h6;       // computed vco rate
    localparam logic [3:0] SCSS_ADDR_DOZE = 4'h7;      // doze ratio

    // oscillator_control field positions
    localparam int SCSS_ACT_LSB = 12;  // active_clock_source 14:12
    localparam int SCSS_REQ_LSB = 8;   // requested_clock_source 10:8
    localparam int SCSS_SW_BIT = 0;    // switch request bit

    // pll_cfg field positions
    localparam int SCSS_PRE_LSB = 0;   // pll_input_divider 4:0
    localparam int SCSS_POST_LSB = 6;  // pll_output_divider 7:6
    localparam int SCSS_DIV_LSB = 16;  // pll_feedback_multiplier 24:16

    // boot_cfg field positions
    localparam int SCSS_INIT_LSB = 0;  // initial_osc_select 2:0
    localparam int SCSS_KIND_LSB = 4;  // primary_osc_kind 5:4
    localparam int SCSS_PIN_BIT = 8;   // second_pin_function_sel

    // source encodings
    localparam logic [2:0] SCSS_SRC_FRC = 3'h0;
    localparam logic [2:0] SCSS_SRC_FAST_RC_WITH_PLL_MODE = 3'h1;
    localparam logic [2:0] SCSS_SRC_PRI = 3'h2;
    localparam logic [2:0] SCSS_SRC_PRIPLL = 3'h3;
    localparam logic [2:0] SCSS_SRC_RSVD = 3'h4;
    localparam logic [2:0] SCSS_SRC_LOW_POWER_RC_OSC = 3'h5;
    localparam logic [2:0] SCSS_SRC_FRC16 = 3'h6;
    localparam logic [2:0] SCSS_SRC_FAST_RC_DIV_N_MODE = 3'h7;

    // primary kind encodings
    localparam logic [1:0] SCSS_KIND_EC = 2'h0;
    localparam logic [1:0] SCSS_KIND_XT = 2'h1;
    localparam logic [1:0] SCSS_KIND_HS = 2'h2;

    // reset values
    localparam logic [2:0] SCSS_ERASED_SRC = 3'h7;  // erased device start source
    localparam logic [4:0] SCSS_PRE_RST = 5'h00;
    localparam logic [1:0] SCSS_POST_RST = 2'h0;
    localparam logic [8:0] SCSS_DIV_RST = 9'h000;
    localparam logic [2:0] SCSS_DOZE_RST = 3'h0;

    // cycles a source change takes before it is reported active
    localparam int SCSS_SWITCH_CYC = 4;

    typedef enum logic [1:0] {
        SCSS_IDLE,
        SCSS_SWITCH,
        SCSS_CALC
    } scss_state_t;

endpackage : scss_pkg

// ==== core/scss_div.sv ====
`timescale 1ns/10ps
// sequential restoring divider, one quotient bit per cycle
module scss_div #(
    parameter int W = 48
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] num_i,
    input wire logic [W-1:0] den_i,
    output logic busy_o,
    output logic [W-1:0] quo_o
);
    typedef struct packed {
        logic [W-1:0] rem;   // partial remainder
        logic [W-1:0] q;     // numerator shifting into quotient
        logic [W-1:0] den;   // held divisor
        logic [7:0] cnt;     // bits left
        logic busy;
    } scss_div_st_t;

    scss_div_st_t st_r, st_nxt;
    logic [W:0] trial;

    // one shift-subtract step per clock
    always_comb begin
        st_nxt = st_r;
        trial = '0;
        if (start_i && !st_r.busy) begin
            st_nxt.rem = '0;
            st_nxt.q = num_i;
            st_nxt.den = den_i;
            st_nxt.cnt = 8'(W);
            st_nxt.busy = 1'b1;
        end else if (st_r.busy) begin
            trial = {st_r.rem, st_r.q[W-1]} - {1'b0, st_r.den};
            if (!trial[W]) begin
                st_nxt.rem = trial[W-1:0];
                st_nxt.q = {st_r.q[W-2:0], 1'b1};
            end else begin
                st_nxt.rem = {st_r.rem[W-2:0], st_r.q[W-1]};
                st_nxt.q = {st_r.q[W-2:0], 1'b0};
            end
            st_nxt.cnt = st_r.cnt - 8'h01;
            st_nxt.busy = (st_r.cnt != 8'h01);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
    assign quo_o = st_r.q;

endmodule : scss_div

// ==== tb/scss_top_tb.sv ====
`timescale 1ns/10ps
module scss_top_tb;
    import scss_pkg::*;
    // source rates, same values handed to the block so expectations match
    localparam logic [31:0] FRC_HZ = 32'h00700000;
    localparam logic [31:0] LOW_POWER_RC_OSC_HZ = 32'h00008000;
    localparam logic [31:0] PRI_HZ = 32'h00800000;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;  // full words only, multiplier needs upper bytes
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [2:0] initial_osc_select_i = 3'h7;  // erased config image
    logic [1:0] primary_osc_kind_i = 2'h0;
    logic second_pin_function_sel_i = 1'b0;
    logic cfg_valid_i = 1'b0;
    logic [2:0] active_clock_source_o;
    logic primary_crystal_en_o;
    logic primary_high_gain_o;
    logic pll_en_o;
    logic second_pin_is_io_o;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] rd;

    scss_top #(.FRC_HZ(FRC_HZ), .LOW_POWER_RC_OSC_HZ(LOW_POWER_RC_OSC_HZ), .PRI_HZ(PRI_HZ)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .initial_osc_select_i(initial_osc_select_i), .primary_osc_kind_i(primary_osc_kind_i),
        .second_pin_function_sel_i(second_pin_function_sel_i), .cfg_valid_i(cfg_valid_i),
        .active_clock_source_o(active_clock_source_o), .primary_crystal_en_o(primary_crystal_en_o),
        .primary_high_gain_o(primary_high_gain_o), .pll_en_o(pll_en_o),
        .second_pin_is_io_o(second_pin_is_io_o)
    );

    // 125 MHz system clock
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // hang guard, the whole run needs well under this many cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // verdict, the single exit of the run
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // one comparison, counted; four-state compare so x never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        // values seen here are those before the edge updates the block; the hang guard ends a stuck wait
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    // bounded wait for the reported source, then judge it
    task automatic wait_act(input logic [2:0] src);
        int n;
        n = 0;
        // a switch may wait behind a rate calculation of about a hundred cycles
        while (active_clock_source_o !== src && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("active source pins", {29'h0, src}, {29'h0, active_clock_source_o});
    endtask : wait_act

    // reset with a given config image; config stays invalid until afterwards
    task automatic do_reset(input logic [2:0] init, input logic [1:0] kind, input logic pin);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        cfg_valid_i <= 1'b0;
        initial_osc_select_i <= init;
        primary_osc_kind_i <= kind;
        second_pin_function_sel_i <= pin;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wait_act(3'h7);
    endtask : do_reset

    // reset state of the control and config registers
    task automatic t_reset();
        bus(1'b0, SCSS_ADDR_OSC_CTRL, 32'h0, rd);
        chk("osc ctrl at reset", 32'h00007700, rd);
        bus(1'b0, SCSS_ADDR_PLL_CFG, 32'h0, rd);
        chk("pll cfg at reset", 32'h0, rd);
        bus(1'b0, SCSS_ADDR_DOZE, 32'h0, rd);
        chk("doze at reset", 32'h0, rd);
        @(posedge sys_clk_i);
        cfg_valid_i <= 1'b1;
        // let the image pass the synchroniser before software touches the request
        repeat (10) @(posedge sys_clk_i);
    endtask : t_reset

    // every legal source except SCSS_SRC_FRC16 requested in turn, then the reserved code
    task automatic t_sources();
        logic [2:0] srcs [6];
        logic [31:0] v;
        srcs = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
        foreach (srcs[i]) begin
            v = {29'h0, srcs[i]};
            bus(1'b1, SCSS_ADDR_OSC_CTRL, v << SCSS_REQ_LSB, rd);
            wait_act(srcs[i]);
            bus(1'b0, SCSS_ADDR_OSC_CTRL, 32'h0, rd);
            chk("osc ctrl fields", (v << SCSS_ACT_LSB) | (v << SCSS_REQ_LSB), rd);
            chk("pll enable", {31'h0, srcs[i] == 3'h1 || srcs[i] == 3'h3}, {31'h0, pll_en_o});
        end
        // reserved source must never be taken
        bus(1'b1, SCSS_ADDR_OSC_CTRL, 32'h00000400, rd);
        repeat (30) @(posedge sys_clk_i);
        chk("reserved source refused", 32'h7, {29'h0, active_clock_source_o});
        bus(1'b0, SCSS_ADDR_OSC_CTRL, 32'h0, rd);
        chk("reserved request kept", 32'h00007400, rd);
    endtask : t_sources

    // divider settings, a source switch, then every computed rate
    task automatic t_rate(input logic [2:0] src, input int pre, input int post, input int mul,
                          input logic [31:0] pll_input_freq, input logic pll);
        logic [63:0] fo;
        logic [63:0] fv;
        fo = pll ? (64'(pll_input_freq) * 64'(mul + 2)) / 64'((pre + 2) * 2 * (post + 1)) : 64'(pll_input_freq);
        fv = pll ? (64'(pll_input_freq) * 64'(mul + 2)) / 64'(pre + 2) : 64'h0;
        bus(1'b1, SCSS_ADDR_PLL_CFG,
            (32'(mul) << SCSS_DIV_LSB) | (32'(post) << SCSS_POST_LSB) | (32'(pre) << SCSS_PRE_LSB), rd);
        bus(1'b1, SCSS_ADDR_OSC_CTRL, {29'h0, src} << SCSS_REQ_LSB, rd);
        wait_act(src);
        // divider needs about a hundred cycles, leave ample margin
        repeat (300) @(posedge sys_clk_i);
        bus(1'b0, SCSS_ADDR_FREQ_LO, 32'h0, rd);
        chk("fosc low word", fo[31:0], rd);
        bus(1'b0, SCSS_ADDR_FREQ_HI, 32'h0, rd);
        chk("fosc high word", {16'h0, fo[47:32]}, rd);
        bus(1'b0, SCSS_ADDR_FCY, 32'h0, rd);
        chk("cpu rate", fo[32:1], rd);
        bus(1'b0, SCSS_ADDR_VCO, 32'h0, rd);
        chk("vco rate", fv[31:0], rd);
    endtask : t_rate

    // an unmapped place, plus the doze ratio field
    task automatic t_regs();
        bus(1'b1, 4'h8, 32'hFFFFFFFF, rd);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        bus(1'b1, SCSS_ADDR_DOZE, 32'h00000005, rd);
        bus(1'b0, SCSS_ADDR_DOZE, 32'h0, rd);
        chk("doze ratio", 32'h00000005, rd);
    endtask : t_regs

    // each primary kind from a fresh reset, pin function requested as io
    task automatic t_kinds();
        logic [1:0] kinds [3];
        kinds = '{SCSS_KIND_HS, SCSS_KIND_XT, SCSS_KIND_EC};
        foreach (kinds[i]) begin
            do_reset(SCSS_SRC_PRI, kinds[i], 1'b1);
            cfg_valid_i <= 1'b1;
            wait_act(SCSS_SRC_PRI);
            chk("crystal enable", {31'h0, kinds[i] != SCSS_KIND_EC}, {31'h0, primary_crystal_en_o});
            chk("high gain", {31'h0, kinds[i] == SCSS_KIND_HS}, {31'h0, primary_high_gain_o});
            chk("second pin io", {31'h0, kinds[i] == SCSS_KIND_EC}, {31'h0, second_pin_is_io_o});
            // config image is read-only, a write must leave it alone
            bus(1'b1, SCSS_ADDR_BOOT_CFG, 32'hFFFFFFFF, rd);
            bus(1'b0, SCSS_ADDR_BOOT_CFG, 32'h0, rd);
            chk("config image", 32'h00000102 | ({30'h0, kinds[i]} << SCSS_KIND_LSB), rd);
        end
    endtask : t_kinds

    // main sequence
    initial begin
        do_reset(3'h7, 2'h0, 1'b0);
        t_reset();
        t_sources();
        t_rate(SCSS_SRC_FAST_RC_WITH_PLL_MODE, 3, 1, 48, FRC_HZ, 1'b1);
        t_rate(SCSS_SRC_PRIPLL, 0, 0, 38, PRI_HZ, 1'b1);
        t_rate(SCSS_SRC_FRC, 0, 0, 38, FRC_HZ, 1'b0);
        t_rate(SCSS_SRC_LOW_POWER_RC_OSC, 2, 3, 100, LOW_POWER_RC_OSC_HZ, 1'b0);
        t_regs();
        t_kinds();
        end_of_test();
    end

endmodule : scss_top_tb
